// ### core/clk_gate_fsm.sv
`timescale 1ns/1ps
`default_nettype none

// Run or gate one clock from its enable, idle timer and wake activity.
module clk_gate_fsm (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control and status inputs.
  input wire logic en,
  input wire logic act,
  input wire logic expired,
  // Registered clock enable.
  output logic clk_en
);
  import clkgate_pkg::*;

  gate_state_t state_q;
  gate_state_t state_d;

  // Wake takes priority over gating, so activity is never swallowed by a gate.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (en && expired && !act) begin
          state_d = ST_GATED;
        end
      end
      ST_GATED: begin
        if (act || !en) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // The enable changes only on a clock edge, so the gate downstream sees no glitch.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RUN;
      clk_en <= 1'b1;
    end else begin
      state_q <= state_d;
      clk_en <= (state_d == ST_RUN);
    end
  end

endmodule // clk_gate_fsm

`default_nettype wire

// ### core/clkgate_pkg.sv
package clkgate_pkg;

  // Core clock rate that every wait period is counted in.
  localparam int unsigned CLK_HZ = 40_000_000;

  // Register bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFFSET = 8'h38;
  localparam logic [7:0] STATUS_OFFSET = 8'h3C;

  // Control register layout and value after reset.
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam int CTRL_RSVD_BIT = 4;
  localparam int SW_EN_BIT = 3;
  localparam int CPU_EN_BIT = 2;
  localparam int WAIT_LSB = 0;
  localparam int WAIT_W = 2;
  localparam int CTRL_USED_W = 5;

  // Status register layout.
  localparam int STAT_SW_GATED_BIT = 0;
  localparam int STAT_CPU_GATED_BIT = 1;

  // Wait period select encodings.
  localparam logic [1:0] WAIT_SEL_5S3 = 2'h0;
  localparam logic [1:0] WAIT_SEL_1S6 = 2'h1;
  localparam logic [1:0] WAIT_SEL_1MS = 2'h2;
  localparam logic [1:0] WAIT_SEL_3U2 = 2'h3;

  // Wait periods in their own units.
  localparam real WAIT_5S3_S = 5.3;
  localparam real WAIT_1S6_S = 1.6;
  localparam real WAIT_1MS_MS = 1.0;
  localparam real WAIT_3U2_US = 3.2;

  // Least times round up; the small offset keeps float noise from adding a cycle.
  localparam int unsigned WAIT_5S3_CYC = int'($ceil(WAIT_5S3_S * CLK_HZ - 0.001));
  localparam int unsigned WAIT_1S6_CYC = int'($ceil(WAIT_1S6_S * CLK_HZ - 0.001));
  localparam int unsigned WAIT_1MS_CYC = int'($ceil(WAIT_1MS_MS * CLK_HZ / 1.0e3 - 0.001));
  localparam int unsigned WAIT_3U2_CYC = int'($ceil(WAIT_3U2_US * CLK_HZ / 1.0e6 - 0.001));

  // Idle counter width, wide enough for the longest period.
  localparam int CNT_W = 28;

  // Number of gated clock channels: switch and CPU.
  localparam int NUM_CH = 2;
  localparam int CH_SW = 0;
  localparam int CH_CPU = 1;
  localparam int NUM_PORTS = 3;

  // Gate controller states.
  typedef enum logic {ST_RUN, ST_GATED} gate_state_t;

endpackage

// ### core/idle_clock_auto_shutdown.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module idle_clock_auto_shutdown #(
  parameter int unsigned WAIT0_CYC = clkgate_pkg::WAIT_5S3_CYC,
  parameter int unsigned WAIT1_CYC = clkgate_pkg::WAIT_1S6_CYC,
  parameter int unsigned WAIT2_CYC = clkgate_pkg::WAIT_1MS_CYC
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic ARST_N,
  // Register bus.
  input wire logic [clkgate_pkg::ADDR_W-1:0] ADDR,
  input wire logic [clkgate_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [clkgate_pkg::DATA_W-1:0] RDATA,
  // Activity from the port MACs and the host interface.
  input wire logic [clkgate_pkg::NUM_PORTS-1:0] MII_BUSY,
  input wire logic HOST_ACT,
  // Clock enables for the downstream glitch-free clock gates.
  output logic SW_CLK_EN,
  output logic CPU_CLK_EN
);
  import clkgate_pkg::*;

  // Reset synchroniser stages.
  logic rst_meta_q;
  logic rst_n;

  // Control register fields.
  logic [CTRL_USED_W-1:0] ctrl_q;
  logic [CTRL_USED_W-1:0] ctrl_d;
  logic sw_en;
  logic cpu_en;
  logic [WAIT_W-1:0] wait_sel;

  // Bus decode.
  logic hit_ctrl;
  logic hit_status;
  logic ctrl_wr;
  logic [DATA_W-1:0] read_word;
  logic [DATA_W-1:0] rdata_d;

  // Activity and channel wiring.
  logic mii_any;
  logic host_any;
  logic [CNT_W-1:0] wait_limit;
  logic [NUM_CH-1:0] ch_en;
  logic [NUM_CH-1:0] ch_act;
  logic [NUM_CH-1:0] ch_expired;
  logic [NUM_CH-1:0] ch_clk_en;

  // Maps a wait period select to its cycle count.
  function automatic logic [CNT_W-1:0] sel_limit(input logic [WAIT_W-1:0] sel);
    logic [CNT_W-1:0] lim;
    lim = CNT_W'(WAIT_3U2_CYC);
    case (sel)
      WAIT_SEL_5S3: lim = CNT_W'(WAIT0_CYC);
      WAIT_SEL_1S6: lim = CNT_W'(WAIT1_CYC);
      WAIT_SEL_1MS: lim = CNT_W'(WAIT2_CYC);
      default: lim = CNT_W'(WAIT_3U2_CYC);
    endcase
    return lim;
  endfunction

  // Release of the external reset is synchronised; assertion stays asynchronous.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Address decode and field extraction.
  assign hit_ctrl = (ADDR == CTRL_OFFSET);
  assign hit_status = (ADDR == STATUS_OFFSET);
  assign ctrl_wr = WR && hit_ctrl;
  assign ctrl_d = ctrl_wr ? WDATA[CTRL_USED_W-1:0] : ctrl_q;
  assign sw_en = ctrl_q[SW_EN_BIT];
  assign cpu_en = ctrl_q[CPU_EN_BIT];
  assign wait_sel = ctrl_q[WAIT_LSB +: WAIT_W];

  // Control register; reserved bit 4 is stored but steers nothing.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET[CTRL_USED_W-1:0];
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Read mux: unmapped addresses and bits 15:5 read as zero; reserved bit 4 reads back as stored.
  always_comb begin
    read_word = '0;
    if (hit_ctrl) begin
      read_word[CTRL_USED_W-1:0] = ctrl_q;
    end else if (hit_status) begin
      read_word[STAT_SW_GATED_BIT] = !SW_CLK_EN;
      read_word[STAT_CPU_GATED_BIT] = !CPU_CLK_EN;
    end
  end

  // Read data stand only in the cycle after the read strobe.
  assign rdata_d = RD ? read_word : '0;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= '0;
    end else begin
      RDATA <= rdata_d;
    end
  end

  // A register access is host activity too, so software polling keeps the CPU awake.
  assign mii_any = |MII_BUSY;
  assign host_any = HOST_ACT || WR || RD;

  // Both channels share one wait period select.
  assign wait_limit = sel_limit(wait_sel);

  // The switch watches the MII only; the CPU also watches the host side.
  assign ch_en[CH_SW] = sw_en;
  assign ch_en[CH_CPU] = cpu_en;
  assign ch_act[CH_SW] = mii_any;
  assign ch_act[CH_CPU] = mii_any || host_any;

  // One idle timer and one gate controller per clock.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      idle_timer u_timer (
        .clk(CLK),
        .rst_n(rst_n),
        .act(ch_act[gi]),
        .limit(wait_limit),
        .expired(ch_expired[gi])
      );
      clk_gate_fsm u_gate (
        .clk(CLK),
        .rst_n(rst_n),
        .en(ch_en[gi]),
        .act(ch_act[gi]),
        .expired(ch_expired[gi]),
        .clk_en(ch_clk_en[gi])
      );
    end
  endgenerate

  // The enables come straight from the controller flip-flops.
  assign SW_CLK_EN = ch_clk_en[CH_SW];
  assign CPU_CLK_EN = ch_clk_en[CH_CPU];

  // Disabled switch gating forces the clock on from the next edge.
  a_sw_always_on: assert property (@(posedge CLK) disable iff (!rst_n)
    !sw_en |=> SW_CLK_EN)
    else $error("switch clock gated while gating is disabled");

  // Disabled CPU gating forces the clock on from the next edge.
  a_cpu_always_on: assert property (@(posedge CLK) disable iff (!rst_n)
    !cpu_en |=> CPU_CLK_EN)
    else $error("CPU clock gated while gating is disabled");

  // Any MII activity wakes a gated switch clock in one cycle.
  a_sw_wake: assert property (@(posedge CLK) disable iff (!rst_n)
    (!SW_CLK_EN && mii_any) |=> SW_CLK_EN)
    else $error("switch clock not woken by MII activity");

  // Host or MII activity wakes a gated CPU clock in one cycle.
  a_cpu_wake: assert property (@(posedge CLK) disable iff (!rst_n)
    (!CPU_CLK_EN && (host_any || mii_any)) |=> CPU_CLK_EN)
    else $error("CPU clock not woken by activity");

  // An expired idle period with gating enabled stops the switch clock.
  a_sw_gate_stop: assert property (@(posedge CLK) disable iff (!rst_n)
    (sw_en && ch_expired[CH_SW] && SW_CLK_EN) |=> !SW_CLK_EN)
    else $error("switch clock not stopped after idle period");

  // An expired idle period with gating enabled stops the CPU clock.
  a_cpu_gate_stop: assert property (@(posedge CLK) disable iff (!rst_n)
    (cpu_en && ch_expired[CH_CPU] && CPU_CLK_EN) |=> !CPU_CLK_EN)
    else $error("CPU clock not stopped after idle period");

  // The switch clock never stops before its idle period has run out.
  a_sw_no_early: assert property (@(posedge CLK) disable iff (!rst_n)
    $fell(SW_CLK_EN) |-> ($past(ch_expired[CH_SW]) && !$past(mii_any)))
    else $error("switch clock stopped before the wait period");

  // The CPU clock never stops before its idle period has run out.
  a_cpu_no_early: assert property (@(posedge CLK) disable iff (!rst_n)
    $fell(CPU_CLK_EN) |-> ($past(ch_expired[CH_CPU]) && !$past(host_any)))
    else $error("CPU clock stopped before the wait period");

  // Helper counts of unbroken idle edges under the shortest period; a long repetition
  // would be slow to check, so the bound is asserted on these counters instead.
  logic [7:0] sw_run_q;
  logic [7:0] cpu_run_q;
  logic sw_short_idle;
  logic cpu_short_idle;

  // A stretch only counts while gating is enabled and the select stays at the shortest period.
  assign sw_short_idle = sw_en && (wait_sel == WAIT_SEL_3U2) && !mii_any;
  assign cpu_short_idle = cpu_en && (wait_sel == WAIT_SEL_3U2) && !ch_act[CH_CPU];

  // The counters saturate, so a clock that stays idle keeps the bound in force.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      sw_run_q <= 8'h00;
      cpu_run_q <= 8'h00;
    end else begin
      sw_run_q <= sw_short_idle ? (sw_run_q + {7'h00, (sw_run_q != 8'hFF)}) : 8'h00;
      cpu_run_q <= cpu_short_idle ? (cpu_run_q + {7'h00, (cpu_run_q != 8'hFF)}) : 8'h00;
    end
  end

  // One idle edge past the shortest period, the switch clock must already be stopped.
  a_sw_short_wait: assert property (@(posedge CLK) disable iff (!rst_n)
    (sw_run_q > 8'(WAIT_3U2_CYC)) |-> !SW_CLK_EN)
    else $error("switch clock not stopped within the short wait period");

  // One idle edge past the shortest period, the CPU clock must already be stopped.
  a_cpu_short_wait: assert property (@(posedge CLK) disable iff (!rst_n)
    (cpu_run_q > 8'(WAIT_3U2_CYC)) |-> !CPU_CLK_EN)
    else $error("CPU clock not stopped within the short wait period");

  // The switch clock can only stop while its gating enable is set.
  a_sw_needs_en: assert property (@(posedge CLK) disable iff (!rst_n)
    $fell(SW_CLK_EN) |-> $past(sw_en))
    else $error("switch clock stopped with gating disabled");

  // The CPU clock can only stop while its gating enable is set.
  a_cpu_needs_en: assert property (@(posedge CLK) disable iff (!rst_n)
    $fell(CPU_CLK_EN) |-> $past(cpu_en))
    else $error("CPU clock stopped with gating disabled");

  // A gated switch clock stays off while the MII stays quiet and gating is enabled.
  a_sw_stay_off: assert property (@(posedge CLK) disable iff (!rst_n)
    (!SW_CLK_EN && sw_en && !mii_any) |=> !SW_CLK_EN)
    else $error("switch clock woke without activity");

  // A gated CPU clock stays off while all its activity sources stay quiet and gating is enabled.
  a_cpu_stay_off: assert property (@(posedge CLK) disable iff (!rst_n)
    (!CPU_CLK_EN && cpu_en && !ch_act[CH_CPU]) |=> !CPU_CLK_EN)
    else $error("CPU clock woke without activity");

  // Activity in the same cycle as an expiry keeps the CPU clock running.
  a_cpu_act_wins: assert property (@(posedge CLK) disable iff (!rst_n)
    (CPU_CLK_EN && ch_act[CH_CPU]) |=> CPU_CLK_EN)
    else $error("CPU clock stopped despite activity");

  // A control write lands on the next edge with only the used bits kept.
  a_ctrl_write: assert property (@(posedge CLK) disable iff (!rst_n)
    ctrl_wr |=> (ctrl_q == $past(WDATA[CTRL_USED_W-1:0])))
    else $error("control write did not land");

  // Without a control write the wait select and enables hold their value.
  a_ctrl_hold: assert property (@(posedge CLK) disable iff (!rst_n)
    !ctrl_wr |=> $stable(ctrl_q))
    else $error("control register changed without a write");

  // Read data stand only in the cycle after a read strobe.
  a_rdata_quiet: assert property (@(posedge CLK) disable iff (!rst_n)
    !RD |=> (RDATA == '0))
    else $error("read data present without a read strobe");

  // The status word reports both gate states as they stood at the read.
  a_status_map: assert property (@(posedge CLK) disable iff (!rst_n)
    (RD && hit_status) |=> (RDATA == {14'h0000, !$past(CPU_CLK_EN), !$past(SW_CLK_EN)}))
    else $error("status read does not match the gate states");

  // Activity in the same cycle as an expiry keeps the switch clock running.
  a_sw_act_wins: assert property (@(posedge CLK) disable iff (!rst_n)
    (SW_CLK_EN && mii_any) |=> SW_CLK_EN)
    else $error("switch clock stopped despite MII activity");

endmodule // idle_clock_auto_shutdown

`default_nettype wire

// ### core/idle_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Counts cycles without activity and saturates at the selected limit.
module idle_timer (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Activity and limit.
  input wire logic act,
  input wire logic [clkgate_pkg::CNT_W-1:0] limit,
  // Idle long enough.
  output logic expired
);
  import clkgate_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic at_limit;

  // Saturating at the limit keeps the counter from wrapping back into the busy range.
  assign at_limit = (cnt_q >= limit);
  assign cnt_d = act ? '0 : (at_limit ? cnt_q : cnt_q + CNT_W'(1));
  assign expired = at_limit && !act;

  // Any activity restarts the count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  a_timer_restart: assert property (@(posedge clk) disable iff (!rst_n)
    act |=> (cnt_q == '0))
    else $error("idle count not restarted by activity");

endmodule // idle_timer

`default_nettype wire

// ### sim/idle_clock_auto_shutdown_tb.sv
`timescale 1ns/1ps
`default_nettype none

module idle_clock_auto_shutdown_tb;
  import clkgate_pkg::*;
  logic clk, arst_n, wr, rd, host_act, sw_en, cpu_en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, v;
  logic [NUM_PORTS-1:0] mii_busy;
  int n_fail, checks, ns, nc;
  logic [15:0] rnd;
  // Idle limits in cycles per wait select, matching the shortened parameters below.
  localparam int LIM [4] = '{300, 200, 100, 128};
  localparam logic [15:0] CTRLS [7] = '{16'h000C, 16'h000D, 16'h000E, 16'h000F,
    16'h000B, 16'h0007, 16'h0003};

  // Long wait periods are shortened so the run stays brief.
  idle_clock_auto_shutdown #(.WAIT0_CYC(300), .WAIT1_CYC(200), .WAIT2_CYC(100))
    u_idle_clock_auto_shutdown (
    .CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .MII_BUSY(mii_busy), .HOST_ACT(host_act),
    .SW_CLK_EN(sw_en), .CPU_CLK_EN(cpu_en));

  // The 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Expected gate delay of one channel, or -1 where that channel must never stop.
  function automatic int exp_gate(input logic [15:0] c, input int b);
    return c[b] ? LIM[c[1:0]] : -1;
  endfunction

  task automatic complete_run();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A gate may land up to two edges late because the enable is a registered level.
  task automatic chk_cnt(input int got, input int exp);
    checks++;
    if ((exp < 0) ? (got != -1) : (got < exp || got > exp + 2)) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data is only valid in the cycle after the strobe, so it is sampled at that negedge.
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // Counts edges since the last activity until each enable drops, bounded at 1000.
  task automatic wait_gate(output int s, output int c);
    s = -1;
    c = -1;
    for (int n = 1; n <= 1000 && (s < 0 || c < 0); n++) begin
      @(posedge clk);
      #1;
      if (s < 0 && sw_en === 1'b0) s = n;
      if (c < 0 && cpu_en === 1'b0) c = n;
    end
  endtask

  // Watchdog sized well beyond the expected run length.
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    complete_run();
  end

  initial begin
    n_fail = 0;
    checks = 0;
    rnd = 16'h004E;
    arst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    host_act = 1'b0;
    addr = '0;
    wdata = '0;
    mii_busy = '0;
    repeat (10) @(posedge clk);
    chk16({15'h0, sw_en}, 16'h0001);
    chk16({15'h0, cpu_en}, 16'h0001);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(CTRL_OFFSET, v);
    chk16(v, CTRL_RESET);
    rd_reg(STATUS_OFFSET, v);
    chk16(v, 16'h0000);
    $display("test reset done");
    // Random writes with random port activity; only the five low bits hold.
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      @(posedge clk);
      mii_busy <= rnd[15:13];
      wr_reg(CTRL_OFFSET, rnd);
      rd_reg(CTRL_OFFSET, v);
      chk16(v, rnd & 16'h001F);
      wr_reg(8'h3A, ~rnd);
      rd_reg(8'h3A, v);
      chk16(v, 16'h0000);
      rd_reg(CTRL_OFFSET, v);
      chk16(v, rnd & 16'h001F);
      // One cycle later the read data must have returned to zero.
      @(negedge clk);
      chk16(rdata, 16'h0000);
    end
    $display("test register done");
    // Each control value is written while a port is busy so both timers start together.
    for (int k = 0; k < 7; k++) begin
      @(posedge clk);
      mii_busy <= 3'b001;
      wr_reg(CTRL_OFFSET, CTRLS[k]);
      mii_busy <= 3'b000;
      wait_gate(ns, nc);
      chk_cnt(ns, exp_gate(CTRLS[k], SW_EN_BIT));
      chk_cnt(nc, exp_gate(CTRLS[k], CPU_EN_BIT));
      if (k < 4) begin
        rnd = lfsr(rnd);
        @(posedge clk);
        mii_busy <= 3'b001 << (rnd[1:0] % 3);
        @(posedge clk);
        mii_busy <= 3'b000;
        #1;
        chk16({15'h0, sw_en}, 16'h0001);
        chk16({15'h0, cpu_en}, 16'h0001);
        // Activity halfway through the idle span must restart the full count.
        repeat (LIM[k] / 2) @(posedge clk);
        mii_busy <= 3'b100;
        @(posedge clk);
        mii_busy <= 3'b000;
        wait_gate(ns, nc);
        chk_cnt(ns, LIM[k]);
        chk_cnt(nc, LIM[k]);
        @(posedge clk);
        host_act <= 1'b1;
        @(posedge clk);
        host_act <= 1'b0;
        #1;
        chk16({15'h0, cpu_en}, 16'h0001);
        chk16({15'h0, sw_en}, 16'h0000);
        // Status shows the switch gated and the CPU running.
        rd_reg(STATUS_OFFSET, v);
        chk16(v, 16'h0001);
        // Clearing the switch enable must reopen its clock with the MII still quiet.
        wr_reg(CTRL_OFFSET, CTRLS[k] & 16'h0007);
        @(posedge clk);
        #1;
        chk16({15'h0, sw_en}, 16'h0001);
      end
      $display("test gate %0d done", k);
    end
    complete_run();
  end
endmodule // idle_clock_auto_shutdown_tb

`default_nettype wire
